// File: design/rfrs_top.sv
// Our own choice: strobed register access.
`include "rfrs_params.svh"

module rfrs_top #(
    parameter int MS_CYCLES = `RFRS_MS_NS / `RFRS_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] code_sel,
    input wire logic mod_data,
    input wire logic frame_done,
    input wire logic err_event,
    input wire logic lv_event,
    output logic frame_start,
    output logic send_active,
    output logic pa_out,
    output logic xtal_power_en,
    output logic vco_boost,
    output logic tx_irq
);
    if (MS_CYCLES < 2) begin : g_bad_ms
        $error("rfrs_top: MS_CYCLES must be at least 2");
    end

    rfrs_pkg::rfrs_top_state_t s;
    rfrs_pkg::rfrs_top_state_t next_s;

    logic ms_tick;
    logic [6:0] lfsr_q;
    logic seed_load;
    logic gap_step;

    // ****************************************
    // millisecond tick and random spacing
    // ****************************************
    rfrs_ms_tick #(
        .DIV(MS_CYCLES)
    ) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(gap_step || seed_load), // restart on every gap load, initial gap too
        .tick(ms_tick)
    );

    rfrs_lfsr u_lfsr (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(seed_load),
        .seed(s.random_seed),
        .step(gap_step),
        .q(lfsr_q)
    );

    // gap length in ms for a given last frame number
    function automatic logic [11:0] gap_len(
        input logic [7:0] base,
        input logic [5:0] fnt,
        input logic [4:0] idx,
        input logic [6:0] rnd
    );
        logic [11:0] prod;
        prod = 12'(fnt) * 12'(idx);
        gap_len = 12'(base) + prod + 12'(rnd);
    endfunction

    // ****************************************
    // decode
    // ****************************************
    logic wr_send;
    logic wr_ctrl3;
    logic wr_base;
    logic wr_seed;
    logic wr_fnt;
    logic wr_stat;

    assign wr_send = reg_wr && (reg_addr == `RFRS_ADDR_SEND);
    assign wr_ctrl3 = reg_wr && (reg_addr == `RFRS_ADDR_FRAME_SPACING_CONTROL);
    assign wr_base = reg_wr && (reg_addr == `RFRS_ADDR_INTERFRAME_BASE_TIME);
    assign wr_seed = reg_wr && (reg_addr == `RFRS_ADDR_VCO_BOOST_RANDOM_SEED);
    assign wr_fnt = reg_wr && (reg_addr == `RFRS_ADDR_FRAME_NUMBER_TIMER);
    assign wr_stat = reg_wr && (reg_addr == `RFRS_ADDR_STATUS_CONTROL);

    // start on a write of one while idle
    assign seed_load = wr_send && reg_wdata[`RFRS_BIT_SEND] && !s.send;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic soft_rst;
        logic [4:0] sent_now;
        soft_rst = wr_stat && reg_wdata[`RFRS_BIT_SOFT_RESET];
        sent_now = s.frames_sent + 5'h01;
        next_s = s;
        next_s.frame_start = 1'b0;
        gap_step = 1'b0;

        // acknowledge first so a same-cycle event still sets its flag
        if (wr_stat && reg_wdata[`RFRS_BIT_ACK]) begin
            next_s.tx_complete_flag = 1'b0;
            next_s.err_flag = 1'b0;
            next_s.lv_flag = 1'b0;
        end
        if (err_event) begin
            next_s.err_flag = 1'b1;
        end
        if (lv_event) begin
            next_s.lv_flag = 1'b1;
        end

        // sequencer, runs only while send is set
        if (s.send) begin
            case (s.state)
                rfrs_pkg::RFRS_FRAME_REQ: begin
                    next_s.frame_start = 1'b1;
                    next_s.state = rfrs_pkg::RFRS_FRAME_WAIT;
                end
                rfrs_pkg::RFRS_FRAME_WAIT: begin
                    if (frame_done) begin
                        next_s.frames_sent = sent_now;
                        if (s.frames_sent == {1'b0, s.frame_count}) begin
                            if (s.completion_delay_select) begin
                                next_s.gap_ms = gap_len(s.base_gap_time,
                                    s.frame_number_timer, sent_now, lfsr_q);
                                next_s.gap_follows_frame = 1'b0;
                                next_s.state = rfrs_pkg::RFRS_GAP;
                                gap_step = 1'b1;
                            end else begin
                                next_s.tx_complete_flag = 1'b1;
                                next_s.send = 1'b0;
                                next_s.state = rfrs_pkg::RFRS_IDLE;
                            end
                        end else begin
                            next_s.gap_ms = gap_len(s.base_gap_time,
                                s.frame_number_timer, sent_now, lfsr_q);
                            next_s.gap_follows_frame = 1'b1;
                            next_s.state = rfrs_pkg::RFRS_GAP;
                            gap_step = 1'b1;
                        end
                    end
                end
                rfrs_pkg::RFRS_GAP: begin
                    if (s.gap_ms == 12'h000) begin
                        if (s.gap_follows_frame) begin
                            next_s.state = rfrs_pkg::RFRS_FRAME_REQ;
                        end else begin
                            next_s.tx_complete_flag = 1'b1;
                            next_s.send = 1'b0;
                            next_s.state = rfrs_pkg::RFRS_IDLE;
                        end
                    end else if (ms_tick) begin
                        next_s.gap_ms = s.gap_ms - 12'h001;
                    end
                end
                default: begin
                    next_s.state = rfrs_pkg::RFRS_IDLE;
                end
            endcase
        end

        // ****************************************
        // register writes
        // ****************************************
        if (wr_send) begin
            if (!reg_wdata[`RFRS_BIT_SEND]) begin
                next_s.send = 1'b0;
                next_s.frame_start = 1'b0;
                next_s.state = rfrs_pkg::RFRS_IDLE;
            end else if (!s.send) begin
                next_s.send = 1'b1;
                next_s.frames_sent = 5'h00;
                if (s.initial_spacing_enable) begin
                    // seed is not in the register yet, use it directly
                    next_s.gap_ms = gap_len(s.base_gap_time,
                        s.frame_number_timer, 5'h00, s.random_seed);
                    next_s.gap_follows_frame = 1'b1;
                    next_s.state = rfrs_pkg::RFRS_GAP;
                end else begin
                    next_s.state = rfrs_pkg::RFRS_FRAME_REQ;
                end
            end
        end
        if (wr_ctrl3) begin
            next_s.data_level = reg_wdata[`RFRS_BIT_DATA_LEVEL];
            next_s.gap_power_down = reg_wdata[`RFRS_BIT_GAP_POWER_DOWN];
            next_s.initial_spacing_enable = reg_wdata[`RFRS_BIT_INITIAL_SPACING];
            next_s.completion_delay_select = reg_wdata[`RFRS_BIT_COMPLETION_DELAY];
            next_s.frame_count = reg_wdata[3:0];
        end
        if (wr_base) begin
            next_s.base_gap_time = reg_wdata;
        end
        if (wr_seed) begin
            next_s.vco_boost = reg_wdata[`RFRS_BIT_VCO_BOOST];
            next_s.random_seed = reg_wdata[6:0];
        end
        if (wr_fnt) begin
            next_s.frame_number_timer = reg_wdata[5:0];
        end
        if (wr_stat) begin
            next_s.tx_irq_enable = reg_wdata[`RFRS_BIT_IRQ_ENABLE];
        end

        // soft reset, base gap kept
        if (soft_rst) begin
            next_s.data_level = 1'b0;
            next_s.gap_power_down = 1'b0;
            next_s.initial_spacing_enable = 1'b0;
            next_s.completion_delay_select = 1'b0;
            next_s.frame_count = 4'h0;
            next_s.vco_boost = 1'b0;
            next_s.random_seed = 7'h00;
            next_s.frame_number_timer = 6'h00;
            next_s.send = 1'b0;
            next_s.tx_complete_flag = 1'b0;
            next_s.err_flag = 1'b0;
            next_s.lv_flag = 1'b0;
            next_s.tx_irq_enable = 1'b0;
            next_s.frame_start = 1'b0;
            next_s.state = rfrs_pkg::RFRS_IDLE;
        end

        // ****************************************
        // registered outputs
        // ****************************************
        if (code_sel == `RFRS_CODE_DIRECT) begin
            next_s.pa_out = next_s.data_level;
        end else begin
            next_s.pa_out = mod_data;
        end
        next_s.xtal_power_en = next_s.send && !(next_s.gap_power_down
            && next_s.state == rfrs_pkg::RFRS_GAP
            && !(next_s.gap_follows_frame
            && next_s.gap_ms <= 12'(`RFRS_RESTART_MS)));
        next_s.tx_irq = next_s.tx_irq_enable && (next_s.tx_complete_flag
            || next_s.err_flag || next_s.lv_flag);

        // read data, one cycle after the strobe
        next_s.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `RFRS_ADDR_SEND: begin
                    next_s.rdata = {s.send, 7'h00};
                end
                `RFRS_ADDR_FRAME_SPACING_CONTROL: begin
                    next_s.rdata = {s.data_level, s.gap_power_down,
                        s.initial_spacing_enable, s.completion_delay_select,
                        s.frame_count};
                end
                `RFRS_ADDR_INTERFRAME_BASE_TIME: begin
                    next_s.rdata = s.base_gap_time;
                end
                `RFRS_ADDR_VCO_BOOST_RANDOM_SEED: begin
                    next_s.rdata = {s.vco_boost, s.random_seed};
                end
                `RFRS_ADDR_FRAME_NUMBER_TIMER: begin
                    next_s.rdata = {2'h0, s.frame_number_timer};
                end
                `RFRS_ADDR_STATUS_CONTROL: begin
                    next_s.rdata = {s.tx_complete_flag, s.err_flag, s.lv_flag,
                        1'b0, s.tx_irq_enable, 3'h0};
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
            s.base_gap_time <= `RFRS_RST_BASE_GAP_TIME;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign frame_start = s.frame_start;
    assign send_active = s.send;
    assign pa_out = s.pa_out;
    assign xtal_power_en = s.xtal_power_en;
    assign vco_boost = s.vco_boost;
    assign tx_irq = s.tx_irq;
endmodule

// File: shared/rfrs_params.svh
`ifndef RFRS_PARAMS_SVH
`define RFRS_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define RFRS_ADDR_SEND 16'h1832
`define RFRS_ADDR_FRAME_SPACING_CONTROL 16'h1833
`define RFRS_ADDR_INTERFRAME_BASE_TIME 16'h1834
`define RFRS_ADDR_VCO_BOOST_RANDOM_SEED 16'h1835
`define RFRS_ADDR_FRAME_NUMBER_TIMER 16'h1836
`define RFRS_ADDR_STATUS_CONTROL 16'h1837

// ****************************************
// field positions
// ****************************************
`define RFRS_BIT_SEND 7
`define RFRS_BIT_DATA_LEVEL 7
`define RFRS_BIT_GAP_POWER_DOWN 6
`define RFRS_BIT_INITIAL_SPACING 5
`define RFRS_BIT_COMPLETION_DELAY 4
`define RFRS_BIT_VCO_BOOST 7
`define RFRS_BIT_TX_COMPLETE 7
`define RFRS_BIT_ERR_FLAG 6
`define RFRS_BIT_LV_FLAG 5
`define RFRS_BIT_ACK 4
`define RFRS_BIT_IRQ_ENABLE 3
`define RFRS_BIT_SOFT_RESET 0

// ****************************************
// reset values and codes
// ****************************************
`define RFRS_RST_BASE_GAP_TIME 8'h80
`define RFRS_CODE_DIRECT 2'h3

// ****************************************
// timing
// ****************************************
`define RFRS_CLK_PERIOD_NS 100
`define RFRS_MS_NS 1000000
`define RFRS_RESTART_MS 1

`endif

// File: shared/rfrs_pkg.sv
package rfrs_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        RFRS_IDLE = 3'b000,
        RFRS_FRAME_REQ = 3'b001,
        RFRS_FRAME_WAIT = 3'b010,
        RFRS_GAP = 3'b011
    } rfrs_state_t;

    // complete state of the sequencer top
    typedef struct packed {
        logic data_level;
        logic gap_power_down;
        logic initial_spacing_enable;
        logic completion_delay_select;
        logic [3:0] frame_count;
        logic [7:0] base_gap_time;
        logic vco_boost;
        logic [6:0] random_seed;
        logic [5:0] frame_number_timer;
        logic send;
        logic tx_complete_flag;
        logic err_flag;
        logic lv_flag;
        logic tx_irq_enable;
        rfrs_state_t state;
        logic [4:0] frames_sent;
        logic [11:0] gap_ms;
        logic gap_follows_frame;
        logic [7:0] rdata;
        logic pa_out;
        logic xtal_power_en;
        logic frame_start;
        logic tx_irq;
    } rfrs_top_state_t;

    // state of the random spacing register
    typedef struct packed {
        logic [6:0] q;
    } rfrs_lfsr_state_t;

endpackage

// File: design/rfrs_ms_tick.sv
module rfrs_ms_tick #(
    parameter int DIV = 10000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clear,
    output logic tick
);
    localparam int CW = $clog2(DIV);

    typedef struct packed {
        logic [CW-1:0] count;
        logic tick;
    } rfrs_tick_state_t;

    rfrs_tick_state_t s;
    rfrs_tick_state_t next_s;

    if (DIV < 2) begin : g_bad_div
        $error("rfrs_ms_tick: DIV must be at least 2");
    end

    // ****************************************
    // divider, restarted by clear
    // ****************************************
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (clear) begin
            next_s.count = '0;
        end else if (s.count == CW'(DIV - 1)) begin
            next_s.count = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.count = s.count + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule

// File: design/rfrs_lfsr.sv
module rfrs_lfsr (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [6:0] seed,
    input wire logic step,
    output logic [6:0] q
);
    rfrs_pkg::rfrs_lfsr_state_t s;
    rfrs_pkg::rfrs_lfsr_state_t next_s;

    // ****************************************
    // x^7 + x^6 + 1, zero is a fixed point
    // ****************************************
    always_comb begin
        next_s = s;
        if (load) begin
            next_s.q = seed;
        end else if (step) begin
            next_s.q = {s.q[5:0], s.q[6] ^ s.q[5]};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.q;
endmodule

// File: test/rfrs_top_props.sv
`include "rfrs_params.svh"

module rfrs_top_props #(
    parameter int MS_CYCLES = 20
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] code_sel,
    input wire logic mod_data,
    input wire logic frame_done,
    input wire logic err_event,
    input wire logic lv_event,
    input wire logic frame_start,
    input wire logic send_active,
    input wire logic pa_out,
    input wire logic xtal_power_en,
    input wire logic vco_boost,
    input wire logic tx_irq
);
    // ****************************************
    // port relations
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    pa_follow_a: assert property (
        code_sel != `RFRS_CODE_DIRECT |=> pa_out == $past(mod_data))
        else $error("pa_out not following coded data");
    start_pulse_a: assert property (frame_start |=> !frame_start)
        else $error("frame start longer than one cycle");
    start_gated_a: assert property (frame_start |-> send_active)
        else $error("frame start without send");
    osc_ready_a: assert property (frame_start |-> xtal_power_en)
        else $error("frame start with oscillator off");
    boost_follow_a: assert property (
        reg_wr && reg_addr == 16'h1835 |=> vco_boost == $past(reg_wdata[7]))
        else $error("boost output not following write");
    base_read_a: assert property (
        reg_wr && reg_addr == 16'h1834 ##2 reg_rd && reg_addr == 16'h1834
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("base gap readback wrong");
    soft_clear_a: assert property (
        reg_wr && reg_addr == 16'h1837 && reg_wdata[0]
        |=> !send_active && !vco_boost ##1 !tx_irq)
        else $error("soft reset left outputs set");
    abort_clear_a: assert property (
        reg_wr && reg_addr == 16'h1832 && !reg_wdata[7] |=> !send_active)
        else $error("send not cleared by abort");
endmodule

bind rfrs_top rfrs_top_props #(.MS_CYCLES(MS_CYCLES)) u_props (.*);

// File: test/rfrs_pa_partner.sv
module rfrs_pa_partner #(
    parameter int FRAME_LEN = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic frame_start,
    output logic frame_done,
    output logic mod_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;

    // serializer stand-in: frame lasts FRAME_LEN cycles, data toggles except while the count is odd
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt <= 0;
            frame_done <= 1'b0;
            mod_data <= 1'b0;
        end else begin
            mod_data <= ~mod_data ^ cnt[0];
            frame_done <= (cnt == 1);
            if (frame_start) begin
                cnt <= FRAME_LEN;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// File: test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 20;
    logic clk, sys_rst, reg_wr, reg_rd, mod_data, frame_done, err_event, lv_event;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic [1:0] code_sel;
    logic frame_start, send_active, pa_out, xtal_power_en, vco_boost, tx_irq, prev_send;
    int error_cnt, total_checks, gap_cnt, first_lat, last_gap, nframes, off_cnt, tail, n;

    rfrs_top #(.MS_CYCLES(MS)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .code_sel(code_sel), .mod_data(mod_data), .frame_done(frame_done),
        .err_event(err_event), .lv_event(lv_event), .frame_start(frame_start),
        .send_active(send_active), .pa_out(pa_out), .xtal_power_en(xtal_power_en),
        .vco_boost(vco_boost), .tx_irq(tx_irq));
    rfrs_pa_partner #(.FRAME_LEN(4)) u_pa (.clk(clk), .sys_rst(sys_rst),
        .frame_start(frame_start), .frame_done(frame_done), .mod_data(mod_data));

    // ****************************************
    // clock, monitor, watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // frame count, gap lengths and oscillator-off time
    always @(posedge clk) begin
        gap_cnt <= frame_done ? 0 : gap_cnt + 1;
        if (frame_start) begin
            if (nframes == 0) first_lat <= gap_cnt;
            else last_gap <= gap_cnt;
            nframes <= nframes + 1;
        end
        if (send_active && !xtal_power_en) off_cnt <= off_cnt + 1;
        if (prev_send && !send_active) tail <= gap_cnt;
        prev_send <= send_active;
    end

    initial begin
        #3000000;
        error_cnt++;
        finish_test();
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask

    function automatic logic near(int v, int ms);
        return v >= ms * MS && v <= ms * MS + 8;
    endfunction

    // one whole datagram, then timing compared in cycles
    task automatic run(input logic [7:0] ctl, base, seed, fnt, input int frames, lat, gap,
        tl, off);
        wr(16'h1833, ctl);
        wr(16'h1834, base);
        wr(16'h1835, seed);
        wr(16'h1836, fnt);
        #1 nframes = 0;
        off_cnt = 0;
        gap_cnt = 0;
        last_gap = 0;
        wr(16'h1832, 8'h80);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (send_active !== 1'b0 && n < 4000);
        // let the monitor register the tail before it is compared
        @(posedge clk);
        #1 chk("ended", send_active, 1'b0);
        chk("frames", nframes, frames);
        chk("first", near(first_lat, lat), 1'b1);
        if (frames > 1) chk("gap", near(last_gap, gap), 1'b1);
        chk("tail", near(tail, tl), 1'b1);
        chk("off", off_cnt >= off * MS - 3 && off_cnt <= off * MS + 3, 1'b1);
        @(posedge clk);
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        code_sel = 2'h0;
        err_event = 1'b0;
        lv_event = 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(16'h1833, rv); chk("ctl rst", rv, 8'h00);
        rd(16'h1834, rv); chk("base rst", rv, 8'h80);
        rd(16'h1835, rv); chk("seed rst", rv, 8'h00);
        rd(16'h1840, rv); chk("unmapped", rv, 8'h00);
        wr(16'h1834, 8'h05);
        rd(16'h1834, rv); chk("base rw", rv, 8'h05);
        wr(16'h1835, 8'h80);
        chk("boost", vco_boost, 1'b1);
        code_sel <= 2'h3;
        wr(16'h1833, 8'h80);
        @(posedge clk);
        #1 chk("pa high", pa_out, 1'b1);
        wr(16'h1833, 8'h00);
        @(posedge clk);
        #1 chk("pa low", pa_out, 1'b0);
        code_sel <= 2'h0;
        wr(16'h1837, 8'h08);
        run(8'h02, 8'h00, 8'h00, 8'h00, 3, 0, 0, 0, 0);
        chk("irq", tx_irq, 1'b1);
        rd(16'h1837, rv); chk("done flag", rv, 8'h88);
        wr(16'h1837, 8'h18);
        rd(16'h1837, rv); chk("acked", rv, 8'h08);
        err_event <= 1'b1;
        lv_event <= 1'b1;
        @(posedge clk);
        err_event <= 1'b0;
        lv_event <= 1'b0;
        rd(16'h1837, rv); chk("ev flags", rv, 8'h68);
        chk("ev irq", tx_irq, 1'b1);
        wr(16'h1837, 8'h00);
        @(posedge clk);
        #1 chk("masked", tx_irq, 1'b0);
        wr(16'h1837, 8'h10);
        run(8'h01, 8'h05, 8'h00, 8'h00, 2, 0, 5, 0, 0);
        run(8'h41, 8'h05, 8'h00, 8'h00, 2, 0, 5, 0, 4);
        run(8'h10, 8'h05, 8'h00, 8'h00, 1, 0, 0, 5, 0);
        run(8'h20, 8'h05, 8'h00, 8'h00, 1, 5, 0, 0, 0);
        run(8'h02, 8'h05, 8'h03, 8'h00, 3, 0, 11, 0, 0);
        run(8'h01, 8'h05, 8'h00, 8'h02, 2, 0, 7, 0, 0);
        wr(16'h1837, 8'h10);
        wr(16'h1834, 8'h32);
        wr(16'h1832, 8'h80);
        n = 0;
        while (frame_done !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("frame seen", frame_done, 1'b1);
        wr(16'h1832, 8'h00);
        #1 nframes = 0;
        repeat (1200) @(posedge clk);
        #1 chk("aborted", send_active, 1'b0);
        chk("no frame", nframes, 0);
        rd(16'h1837, rv); chk("no flag", rv, 8'h00);
        wr(16'h1835, 8'h85);
        wr(16'h1833, 8'h5f);
        wr(16'h1837, 8'h01);
        rd(16'h1833, rv); chk("ctl soft", rv, 8'h00);
        rd(16'h1834, rv); chk("base kept", rv, 8'h32);
        rd(16'h1835, rv); chk("seed soft", rv, 8'h00);
        chk("boost soft", vco_boost, 1'b0);
        finish_test();
    end
endmodule
